// ---- common/backend_pkg.sv ----
// Shared constants and carriers for the filter back-end output stage.
// Assumes a single clock domain and a byte-wide register write port.
package backend_pkg;
  localparam int DATA_W     = 22;
  localparam int LUT_W      = 27;
  localparam int REG_ADDR_W = 2;
  // Register indices on the byte-wide control port
  localparam logic [1:0] ADDR_STATS = 2'h1;
  localparam logic [1:0] ADDR_LUTPS = 2'h2;
  localparam logic [1:0] ADDR_NORM  = 2'h3;
  // Writable bit masks; reserved positions read as zero
  localparam logic [7:0] MASK_STATS = 8'h03;
  localparam logic [7:0] MASK_LUTPS = 8'h7f;
  localparam logic [7:0] MASK_NORM  = 8'hfe;
  localparam logic [7:0] RESET_VAL  = 8'h00;
  // Field positions
  localparam int STATIC_BIT  = 1;
  localparam int GREATER_BIT = 0;
  localparam int PASS_LO_BIT = 6;
  localparam int PASS_HI_BIT = 5;
  localparam int PRESC_LSB   = 0;
  localparam int NORM_LSB    = 3;
  localparam int DYN_BIT     = 2;
  localparam int FEED_BIT    = 1;
  localparam int SHIFT_W     = 5;
  localparam int PRESC_MAX   = 16;
  localparam int NORM_MIN    = -2;
  localparam int NORM_MAX    = 14;
  localparam int DYN_LSB     = 22;
  localparam int LO_LSB      = 0;
  localparam int HI_LSB      = 14;

  typedef struct packed {
    logic                  wr;
    logic [REG_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
  } reg_req_t;

  typedef struct packed {
    logic       static_thr;
    logic       greater;
    logic       pass_lo;
    logic       pass_hi;
    logic [4:0] presc;
    logic [4:0] norm;
    logic       dyn_norm;
    logic       lut_feed;
  } ctrl_t;
endpackage

// ---- rtl/stats_monitor.sv ----
// Statistics monitor: comparator, over/undershoot counter and extremum register.
// Assumes samples arrive with a valid strobe in the core clock domain.
`timescale 1ns/10ps
module stats_monitor #(
  parameter int W     = 22,
  parameter int CNT_W = 16
) (
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  input  wire logic                sample_vld,
  input  wire logic signed [W-1:0] sample,
  input  wire logic                static_thr,
  input  wire logic                greater,
  input  wire logic                clear,
  output logic signed [W-1:0]      extremum_register_q,
  output logic [CNT_W-1:0]         hit_count_q
);
  logic hit;

  // Both comparator senses against the stored threshold
  assign hit = sample_vld && (greater ? (sample > extremum_register_q)
                                      : (sample < extremum_register_q)); // [R3]

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hit_count_q <= '0;
    end else if (clk_en) begin
      if (hit) begin
        hit_count_q <= hit_count_q + 1'b1; // [R1] [R2]
      end else if (clear) begin
        hit_count_q <= '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      extremum_register_q <= '0;
    end else if (clk_en) begin
      // A hit in static mode leaves the threshold alone
      if (hit && !static_thr) begin
        extremum_register_q <= sample; // [R2]
      end
    end
  end
endmodule // stats_monitor

// ---- rtl/backend_shifter.sv ----
// Prescaler and normaliser shifters of the back end.
// Purely combinational; the caller registers only the normaliser result, after the output adder.
`timescale 1ns/10ps
module backend_shifter #(
  parameter int W = 22
) (
  input  wire logic signed [W-1:0] presc_in,
  input  wire logic [4:0]          presc_sh,
  input  wire logic signed [W-1:0] norm_in,
  input  wire logic [4:0]          norm_sh,
  output logic signed [W-1:0]      presc_out,
  output logic signed [W-1:0]      norm_out
);
  import backend_pkg::*;
  logic signed [5:0] nsh;

  // Values above sixteen are undefined; the hardware simply shifts further
  assign presc_out = presc_in >>> presc_sh; // [R7]

  assign nsh = 6'(signed'(norm_sh));
  always_comb begin
    if (nsh < 6'(NORM_MIN) || nsh > 6'(NORM_MAX)) begin
      norm_out = '0; // [R10]
    end else if (nsh[5]) begin
      norm_out = norm_in <<< (6'd0 - nsh); // [R9]
    end else begin
      norm_out = norm_in >>> nsh; // [R9]
    end
  end
endmodule // backend_shifter

// ---- rtl/filter_backend_output_stage.sv ----
// Back end of the multiply-accumulate filter: cascade adder, statistics monitor,
// look-up prescaler, normaliser, output adder and cascade output multiplexer.
// Assumes the mac array result, cascade input and look-up table data arrive
// synchronous to core_clk; registers are written over a byte-wide host port.
//
// Function
// R1: With static threshold set, a comparator hit only increments the counter.
// R2: With static threshold clear, a hit loads the cascade sum as threshold and increments the counter.
// R3: The greater bit picks greater-than or less-than, giving the four monitor modes.
// R4: Reserved control bits read back zero and software writes them as zero; the bench writes random values with bit 7 set to check the masks.
// R5: Low-byte pass puts the selected table byte on cascade output bits 7..0.
// R6: High-byte pass puts the selected table byte on cascade output bits 21..14.
// R7: The prescaler arithmetically right-shifts by its 0..16 field.
// R8: Software keeps the prescaler field within 0..16.
// R9: The normaliser count is two's complement, right when positive, from -2 to +14.
// R10: A normaliser count outside -2..+14 yields zero.
// R11: Dynamic normalisation takes the count from table bits 26..22.
// R12: The output adder's second input is zero or table bits 21..0 by the feed bit.
// R13: The zero-cascade bit feeds zero to the cascade adder instead of cascade data.
// R14: While the table belongs to the memory interface its output is zero and the register count is used.
// R15: All control fields reset to zero.
`timescale 1ns/10ps
module filter_backend_output_stage
  import backend_pkg::*;
#(
  parameter int W     = backend_pkg::DATA_W,
  parameter int CNT_W = 16
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  input  wire logic                          clk_en,
  input  wire backend_pkg::reg_req_t         reg_req,
  input  wire logic [backend_pkg::REG_ADDR_W-1:0] rd_addr,
  input  wire logic                          sample_vld,
  input  wire logic signed [W-1:0]           mac_result,
  input  wire logic signed [W-1:0]           cascade_in,
  input  wire logic                          zero_cascade,
  input  wire logic                          lut_enable,
  input  wire logic [backend_pkg::LUT_W-1:0] lut_data,
  input  wire logic [7:0]                    lut_byte,
  input  wire logic                          stats_clear,
  output logic [7:0]                         rd_data_q,
  output logic signed [W-1:0]                cascade_out_q,
  output logic                               cascade_vld_q,
  output logic signed [W-1:0]                extremum_q,
  output logic [CNT_W-1:0]                   hit_count_q
);
  import backend_pkg::*;

  logic [7:0]                stats_ctl_q;
  logic [7:0]                lutps_ctl_q;
  logic [7:0]                norm_ctl_q;
  ctrl_t                     ctl;
  logic signed [W-1:0]       casc_sel;
  logic signed [W-1:0]       casc_sum;
  logic [LUT_W-1:0]          lut_eff;
  logic signed [W-1:0]       presc_out;
  logic signed [W-1:0]       norm_out;
  logic [4:0]                norm_sh;
  logic signed [W-1:0]       adder_b;
  logic signed [W-1:0]       out_sum;
  logic signed [W-1:0]       mux_out;
  logic signed [W-1:0]       ext_w;
  logic [CNT_W-1:0]          cnt_w;

  function automatic logic [7:0] reg_mask(input logic [REG_ADDR_W-1:0] a);
    case (a)
      ADDR_STATS: reg_mask = MASK_STATS;
      ADDR_LUTPS: reg_mask = MASK_LUTPS;
      ADDR_NORM:  reg_mask = MASK_NORM;
      default:    reg_mask = 8'h00;
    endcase
  endfunction

  // Register writes; reserved bits are never stored
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stats_ctl_q <= RESET_VAL; // [R15]
      lutps_ctl_q <= RESET_VAL; // [R15]
      norm_ctl_q  <= RESET_VAL; // [R15]
    end else if (clk_en && reg_req.wr) begin
      case (reg_req.addr)
        ADDR_STATS: stats_ctl_q <= reg_req.wdata & reg_mask(ADDR_STATS); // [R4]
        ADDR_LUTPS: lutps_ctl_q <= reg_req.wdata & reg_mask(ADDR_LUTPS); // [R4]
        ADDR_NORM:  norm_ctl_q  <= reg_req.wdata & reg_mask(ADDR_NORM);  // [R4]
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rd_data_q <= 8'h00;
    end else if (clk_en) begin
      case (rd_addr)
        ADDR_STATS: rd_data_q <= stats_ctl_q & reg_mask(ADDR_STATS); // [R4]
        ADDR_LUTPS: rd_data_q <= lutps_ctl_q & reg_mask(ADDR_LUTPS); // [R4]
        ADDR_NORM:  rd_data_q <= norm_ctl_q & reg_mask(ADDR_NORM);   // [R4]
        default:    rd_data_q <= 8'h00;
      endcase
    end
  end

  always_comb begin
    ctl.static_thr = stats_ctl_q[STATIC_BIT];
    ctl.greater    = stats_ctl_q[GREATER_BIT];
    ctl.pass_lo    = lutps_ctl_q[PASS_LO_BIT];
    ctl.pass_hi    = lutps_ctl_q[PASS_HI_BIT];
    ctl.presc      = lutps_ctl_q[PRESC_LSB +: SHIFT_W];
    ctl.norm       = norm_ctl_q[NORM_LSB +: SHIFT_W];
    ctl.dyn_norm   = norm_ctl_q[DYN_BIT];
    ctl.lut_feed   = norm_ctl_q[FEED_BIT];
  end

  assign casc_sel = zero_cascade ? '0 : cascade_in; // [R13]
  assign casc_sum = W'(mac_result + casc_sel);

  // Table held by the memory interface gives zero to the data path
  assign lut_eff = lut_enable ? lut_data : '0; // [R14]
  assign norm_sh = (ctl.dyn_norm && lut_enable) ? lut_eff[DYN_LSB +: SHIFT_W]
                                                : ctl.norm; // [R11] [R14]
  assign adder_b = ctl.lut_feed ? W'(lut_eff[W-1:0]) : '0; // [R12]

  backend_shifter #(
    .W (W)
  ) u_shift (
    .presc_in  (casc_sum),
    .presc_sh  (ctl.presc),
    .norm_in   (casc_sum),
    .norm_sh   (norm_sh),
    .presc_out (presc_out),
    .norm_out  (norm_out)
  );

  // The prescaled value is what addresses the table outside; it does not enter
  // the output adder, which sums the normaliser result and the feed input.
  assign out_sum = W'(norm_out + adder_b);

  always_comb begin
    mux_out = out_sum;
    if (ctl.pass_lo) begin
      mux_out[LO_LSB +: 8] = lut_enable ? lut_byte : 8'h00; // [R5]
    end
    if (ctl.pass_hi) begin
      mux_out[HI_LSB +: 8] = lut_enable ? lut_byte : 8'h00; // [R6]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cascade_out_q <= '0;
      cascade_vld_q <= 1'b0;
    end else if (clk_en) begin
      cascade_out_q <= mux_out;
      cascade_vld_q <= sample_vld;
    end
  end

  stats_monitor #(
    .W     (W),
    .CNT_W (CNT_W)
  ) u_stats (
    .core_clk            (core_clk),
    .rst_b               (rst_b),
    .clk_en              (clk_en),
    .sample_vld          (sample_vld),
    .sample              (casc_sum),
    .static_thr          (ctl.static_thr),
    .greater             (ctl.greater),
    .clear               (stats_clear),
    .extremum_register_q (ext_w),
    .hit_count_q         (cnt_w)
  );

  // Wires straight from the monitor's flip-flops
  assign extremum_q  = ext_w;
  assign hit_count_q = cnt_w;

  // Unused here except as a debug tap: the prescaled value feeds the table address
  logic unused_presc;
  assign unused_presc = ^presc_out;
endmodule // filter_backend_output_stage

// ---- dv/backend_monitor.sv ----
// Port checker for the filter back-end output stage, bound to every instance.
// Assumes one clock; control bits it needs are mirrored from the write port.
`timescale 1ns/10ps
module backend_monitor
  import backend_pkg::*;
#(
  parameter int W     = DATA_W,
  parameter int CNT_W = 16
) (
  input wire logic                  core_clk,
  input wire logic                  rst_b,
  input wire logic                  clk_en,
  input wire reg_req_t              reg_req,
  input wire logic [REG_ADDR_W-1:0] rd_addr,
  input wire logic                  sample_vld,
  input wire logic signed [W-1:0]   mac_result,
  input wire logic signed [W-1:0]   cascade_in,
  input wire logic                  zero_cascade,
  input wire logic                  lut_enable,
  input wire logic [LUT_W-1:0]      lut_data,
  input wire logic [7:0]            lut_byte,
  input wire logic                  stats_clear,
  input wire logic [7:0]            rd_data_q,
  input wire logic signed [W-1:0]   cascade_out_q,
  input wire logic                  cascade_vld_q,
  input wire logic signed [W-1:0]   extremum_q,
  input wire logic [CNT_W-1:0]      hit_count_q
);
  localparam logic [7:0] MASK_TAB [4] = '{8'h00, MASK_STATS, MASK_LUTPS, MASK_NORM};
  logic [1:0]          st_q;
  logic [1:0]          ps_q;
  logic signed [W-1:0] sum;
  logic                hit;
  logic [7:0]          byte_sel;
  // Mirror only the bits the checks depend on; written values land next edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= 2'h0;
      ps_q <= 2'h0;
    end else if (clk_en && reg_req.wr) begin
      if (reg_req.addr == ADDR_STATS) st_q <= reg_req.wdata[1:0];
      if (reg_req.addr == ADDR_LUTPS) ps_q <= reg_req.wdata[6:5];
    end
  end
  assign sum = mac_result + (zero_cascade ? '0 : cascade_in);
  assign hit = sample_vld && (st_q[0] ? sum > extremum_q : sum < extremum_q);
  assign byte_sel = lut_enable ? lut_byte : 8'h00;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_hit;
    clk_en && hit && !stats_clear;
  endsequence
  sequence s_load;
    s_hit ##0 !st_q[1];
  endsequence
  static_hold_a: assert property (clk_en && st_q[1] |=> extremum_q == $past(extremum_q))
    else $error("extremum moved in static mode");
  ext_load_a: assert property (s_load |=> extremum_q == $past(sum))
    else $error("extremum not loaded with cascade sum");
  count_inc_a: assert property (s_hit |=> hit_count_q == $past(hit_count_q) + 1'b1)
    else $error("counter missed a hit");
  count_hold_a: assert property (clk_en && !hit && !stats_clear |=> $stable(hit_count_q))
    else $error("counter moved without a hit");
  read_mask_a: assert property (clk_en |=> (rd_data_q & ~MASK_TAB[$past(rd_addr)]) == 8'h00)
    else $error("reserved bit read as one");
  pass_lo_a: assert property (clk_en && ps_q[1] |=> cascade_out_q[7:0] == $past(byte_sel))
    else $error("low output byte not the table byte");
  pass_hi_a: assert property (clk_en && ps_q[0] |=> cascade_out_q[21:14] == $past(byte_sel))
    else $error("high output byte not the table byte");
  state_freeze_a: assert property (!clk_en |=> $stable({cascade_out_q, cascade_vld_q, rd_data_q, extremum_q, hit_count_q}))
    else $error("state moved while clock enable low");
endmodule // backend_monitor

bind filter_backend_output_stage backend_monitor #(.W(W), .CNT_W(CNT_W)) mon_u (
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_req(reg_req), .rd_addr(rd_addr),
  .sample_vld(sample_vld), .mac_result(mac_result), .cascade_in(cascade_in), .zero_cascade(zero_cascade),
  .lut_enable(lut_enable), .lut_data(lut_data), .lut_byte(lut_byte), .stats_clear(stats_clear),
  .rd_data_q(rd_data_q), .cascade_out_q(cascade_out_q), .cascade_vld_q(cascade_vld_q),
  .extremum_q(extremum_q), .hit_count_q(hit_count_q));

// ---- dv/lut_model.sv ----
// Look-up table stand-in: a table word and selected byte for an index.
// Combinational, like a table read that the data path samples each edge.
`timescale 1ns/10ps
module lut_model
  import backend_pkg::*;
(
  input  wire logic [7:0] idx,
  output logic [LUT_W-1:0] word,
  output logic [7:0]       sel_byte
);
  // Shift field kept 0..7 so dynamic counts never hit the zeroing range
  assign word = {2'h0, idx[2:0], 14'h0, idx};
  assign sel_byte = ~idx;
endmodule // lut_model

// ---- dv/filter_backend_output_stage_tb.sv ----
// Self-checking bench for the filter back-end output stage.
// Inputs change 1 ns after each rising edge; the table stand-in answers at once.
`timescale 1ns/10ps
module filter_backend_output_stage_tb;
  import backend_pkg::*;
  logic core_clk = 0, rst_b = 0, clk_en = 1, sample_vld = 0, zero_cascade = 0, lut_enable = 0;
  logic stats_clear = 0, cascade_vld_q, h;
  reg_req_t reg_req = '0;
  logic [1:0] rd_addr = 0;
  logic signed [21:0] mac_result = 0, cascade_in = 0, cascade_out_q, extremum_q, ext_m = 0, s, e;
  logic [26:0] lut_data;
  logic [7:0] lut_byte, idx = 0, rd_data_q, ps = 0, nm = 0, rv;
  logic [15:0] hit_count_q, cnt_m;
  int fail_count = 0, check_count = 0;
  localparam logic [7:0] MASK_TAB [4] = '{8'h00, MASK_STATS, MASK_LUTPS, MASK_NORM};
  lut_model table_u (.idx(idx), .word(lut_data), .sel_byte(lut_byte));
  filter_backend_output_stage dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_req(reg_req),
    .rd_addr(rd_addr), .sample_vld(sample_vld), .mac_result(mac_result), .cascade_in(cascade_in),
    .zero_cascade(zero_cascade), .lut_enable(lut_enable), .lut_data(lut_data), .lut_byte(lut_byte),
    .stats_clear(stats_clear), .rd_data_q(rd_data_q), .cascade_out_q(cascade_out_q),
    .cascade_vld_q(cascade_vld_q), .extremum_q(extremum_q), .hit_count_q(hit_count_q));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_dat(input logic [21:0] got, input logic [21:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // A spare cycle after each write lets the read-back register take the new value before the check
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_req = '{1'b1, a, d};
    @(posedge core_clk);
    #1 reg_req.wr = 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  function automatic logic [21:0] exp_out(logic signed [21:0] sm, logic le, logic [7:0] a);
    logic signed [4:0] k;
    logic [26:0] l;
    logic signed [21:0] r;
    l = le ? {2'h0, a[2:0], 14'h0, a} : 27'h0;
    k = (nm[2] && le) ? l[26:22] : nm[7:3];
    r = (k < -2 || k > 14) ? 22'sh0 : (k < 0 ? sm <<< -k : sm >>> k);
    if (nm[1]) r = r + l[21:0];
    if (ps[6]) r[7:0] = le ? ~a : 8'h00;
    if (ps[5]) r[21:14] = le ? ~a : 8'h00;
    return r;
  endfunction
  initial begin
    #60000;
    fail_count++;
    test_done();
  end
  initial begin
    void'($urandom(67719));
    repeat (2) @(posedge core_clk);
    #1 rst_b = 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd_addr = 2'(a);
      @(posedge core_clk);
      #1 chk_reg(rd_data_q, 8'h00);
      rv = 8'($urandom) | 8'h80;
      if (a == 2) rv[4:0] = 5'(rv[4:0] % 17);
      wr(2'(a), rv);
      chk_reg(rd_data_q, rv & MASK_TAB[a]);
    end
    for (int m = 0; m < 4; m++) begin
      // The last random cycle may have left the enable low; writes and clears need it high
      clk_en = 1'b1;
      sample_vld = 1'b0;
      wr(ADDR_STATS, 8'(m));
      stats_clear = 1'b1;
      @(posedge core_clk);
      #1 stats_clear = 1'b0;
      cnt_m = 16'h0;
      repeat (40) begin
        clk_en = ($urandom % 8) != 0;
        sample_vld = 1'($urandom);
        mac_result = $signed(10'($urandom));
        cascade_in = $signed(8'($urandom));
        zero_cascade = 1'($urandom);
        s = mac_result + (zero_cascade ? 22'sh0 : cascade_in);
        h = clk_en && sample_vld && (m[0] ? s > ext_m : s < ext_m);
        if (h) cnt_m++;
        if (h && !m[1]) ext_m = s;
        @(posedge core_clk);
        #1 chk_dat(22'(hit_count_q), 22'(cnt_m));
        chk_dat(extremum_q, ext_m);
      end
    end
    clk_en = 1'b1;
    for (int c = 0; c < 12; c++) begin
      ps = {1'b0, 2'($urandom), 5'($urandom % 17)};
      nm = c == 0 ? 8'hf0 : c == 1 ? 8'h70 : c == 2 ? 8'h7a : 8'($urandom) & MASK_NORM;
      lut_enable = 1'($urandom);
      wr(ADDR_LUTPS, ps);
      wr(ADDR_NORM, nm);
      repeat (20) begin
        mac_result = 22'($urandom);
        cascade_in = 22'($urandom);
        zero_cascade = 1'($urandom);
        sample_vld = 1'($urandom);
        idx = 8'($urandom);
        s = mac_result + (zero_cascade ? 22'sh0 : cascade_in);
        e = exp_out(s, lut_enable, idx);
        // The prescaler only reaches the table address outside, so it is probed inside
        #1 chk_dat(dut.presc_out, s >>> ps[4:0]);
        @(posedge core_clk);
        #1 chk_dat(cascade_out_q, e);
        chk_reg({7'h00, cascade_vld_q}, {7'h00, sample_vld});
      end
    end
    test_done();
  end
endmodule // filter_backend_output_stage_tb
